//--- src/fsd_pkg.sv
// constants, layouts and types of the slave diagnostics frame builder
package fsd_pkg;
  // frame layout, byte offsets
  localparam int STAT1_BYTE = 0;
  localparam int STAT2_BYTE = 1;
  localparam int STAT3_BYTE = 2;
  localparam int MADDR_BYTE = 3;
  localparam int IDDIAG_BYTE = 6;
  localparam int IDDIAG_LEN = 9;
  localparam int MODSTAT_BYTE = IDDIAG_BYTE + IDDIAG_LEN;
  localparam int MODSTAT_LEN = 20;
  localparam int CHAN_BYTE = MODSTAT_BYTE + MODSTAT_LEN;
  localparam int CHAN_LEN = 3;
  localparam int CHAN_MAX = 9;
  localparam int SLOT_FIELD_BYTE = 35;
  localparam int PWR_FIELD_BYTE = 36;
  localparam int FRAME_MIN = 6;
  localparam int FRAME_MAX_V0 = 62;
  localparam int FRAME_MAX_V1 = 110;
  localparam int FRAME_BUF = 128;
  localparam int IRQ_MAX = 48;
  localparam int IRQ_HDR = 4;
  // station status 2 bit positions
  localparam int S2_REPARAM = 0;
  localparam int S2_STATIC = 1;
  localparam int S2_ONE = 2;
  localparam int S2_WDOG = 3;
  localparam int S2_FREEZE = 4;
  localparam int S2_SYNC = 5;
  localparam int S2_ZERO = 6;
  localparam int S2_DISABLED = 7;
  localparam int S3_OVERFLOW = 7;
  localparam int ID_BITS = 63;
  localparam int SLOTS = 63;
  localparam logic [1:0] MOD_ERR = 2'h1;
  localparam logic [1:0] MOD_NONE = 2'h3;
  // diagnostic records
  localparam int REC0_LEN = 4;
  localparam int REC1_EXTRA = 40;
  localparam int REC1_LEN = REC0_LEN + REC1_EXTRA;
  localparam int PROC_LEN = 4;
  // register map, byte addresses
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STATUS = 8'h04;
  localparam logic [7:0] A_MADDR = 8'h08;
  localparam logic [7:0] A_CHAN = 8'h0c;
  localparam logic [7:0] A_IRQ = 8'h10;
  localparam logic [7:0] A_REC_IDX = 8'h14;
  localparam logic [7:0] A_REC_DATA = 8'h18;
  localparam logic [7:0] A_FRM_IDX = 8'h1c;
  localparam logic [7:0] A_FRM_DATA = 8'h20;
  localparam logic [7:0] A_LEN = 8'h24;
  localparam logic [7:0] A_IDDIAG_LO = 8'h28;
  localparam logic [7:0] A_IDDIAG_HI = 8'h2c;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  typedef enum logic [1:0] {IRQ_NONE = 2'h0, IRQ_DIAG = 2'h1,
                            IRQ_PROC = 2'h3, IRQ_PLUG = 2'h2} fsd_irq_e;
  // build walk states, gray along the usual path
  typedef enum logic [1:0] {ST_IDLE = 2'h0, ST_BUILD = 2'h1,
                            ST_DONE = 2'h3} fsd_state_e;
endpackage : fsd_pkg

//--- src/fsd_rec_if.sv
// carrier between frame builder and its diagnostic record store
`timescale 1ns/1ps
`default_nettype none
interface fsd_rec_if;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic wr_en;
  logic [5:0] rd_addr;
  logic [7:0] rd_data;
  logic [5:0] rec1_len;
  modport store (input wr_addr, wr_data, wr_en, rd_addr,
                 output rd_data, rec1_len);
  modport user (output wr_addr, wr_data, wr_en, rd_addr,
                input rd_data, rec1_len);
endinterface : fsd_rec_if
`default_nettype wire

//--- src/fsd_rec_store.sv
// diagnostic record zero and one storage
`timescale 1ns/1ps
`default_nettype none
module fsd_rec_store
  import fsd_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // record port
  fsd_rec_if.store rec
);
  // record one begins with a copy of record zero, so one array serves both
  logic [7:0] mem_q [REC1_LEN];
  logic [5:0] len_q;

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (int i = 0; i < REC1_LEN; i++)
        mem_q[i] <= 8'h00;
    end
    else if (rec.wr_en && rec.wr_addr < 8'(REC1_LEN))
    begin
      mem_q[rec.wr_addr[5:0]] <= rec.wr_data; // R16
    end
  end

  // length of record one follows the highest byte written
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      len_q <= 6'(REC0_LEN);
    else if (rec.wr_en && rec.wr_addr < 8'(REC1_LEN)
             && rec.wr_addr[5:0] >= len_q)
      len_q <= rec.wr_addr[5:0] + 6'h01;
  end

  assign rec.rd_data = (rec.rd_addr < 6'(REC1_LEN)) ?
                       mem_q[rec.rd_addr] : 8'h00;
  assign rec.rec1_len = len_q;
endmodule : fsd_rec_store
`default_nettype wire

//--- src/fsd_frame.sv
// slave diagnostics frame builder with an ahb-lite register slave
//
// The address map and register access over AHB-Lite were decided locally.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// [R01] byte 1 bit 0 flags that parameters must be assigned again
// [R02] byte 1 bit 1 flags a static diagnostic; data exchange withheld meanwhile
// [R03] byte 1 bit 2 always one, bit 6 always zero
// [R04] byte 1 bit 3 shows the response watchdog is active
// [R05] freeze and sync bits refresh only when other content changes
// [R06] byte 1 bit 7 shows the slave is disabled from cyclic processing
// [R07] byte 2 bits 0 to 6 zero, bit 7 master buffer overflow
// [R08] byte 3 holds the address of the parameterising master
// [R09] fault summary sits at byte 6, nine bytes long
// [R10] twenty byte module status follows the fault summary
// [R11] up to nine channel entries, frame within 62 or 110 bytes
// [R12] module status is independent of channel entries
// [R13] byte 35 bits 0 to 5 hold slot number minus one
// [R14] byte 36 bits 6 and 7 are 00 for a power module
// [R15] dpv1 only: interrupt section up to 48 bytes after channel entries
// [R16] record zero four bytes, record one repeats it plus forty, both readable
// [R17] interrupt payload 44, 4 or 0 bytes by interrupt type; code sizes the diag payload by rec1_len, 4 to 44
// [R18] fatal configuration faults fail the station regardless of tolerance
// [R19] invalid configuration sets 63 summary bits, module status 01 then 11; code sets all 72 bits of the nine bytes
// [R20] one missing module at power-on blocks startup
// [R21] after failure stop user data, keep diagnostics and record reads
// [R22] frame length 6 to 62 bytes in dpv0, 6 to 110 in dpv1
// [R23] each channel entry takes three bytes
module fsd_frame
  import fsd_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // events from the link and the backplane
  input wire logic freeze_seen,
  input wire logic sync_seen,
  input wire logic wdog_active,
  input wire logic master_overflow,
  input wire logic missing_one,
  input wire logic missing_two,
  input wire logic term_missing,
  input wire logic too_many,
  input wire logic backplane_fault,
  input wire logic cause_found,
  input wire logic powered_up,
  // station state
  output logic data_exchange_en,
  output logic station_fail,
  output logic frame_valid
);
  // ---------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------
  logic [31:0] ctrl_q;
  logic [7:0] maddr_q;
  logic [62:0] iddiag_q;
  logic [3:0] chan_cnt_q;
  logic [5:0] chan_slot_q [CHAN_MAX];
  logic chan_pwr_q [CHAN_MAX];
  logic [7:0] chan_code_q [CHAN_MAX];
  logic [1:0] irq_type_q;
  logic [6:0] frm_idx_q;
  logic [7:0] frm_q [FRAME_BUF];
  logic [6:0] frm_len_q;
  logic [5:0] rec_idx_q;
  logic freeze_q, sync_q, startup_blk_q;
  logic [7:0] stat2_q, stat3_q;
  fsd_state_e state_q;
  logic [6:0] walk_q;
  fsd_rec_if rec ();

  // ctrl fields
  logic reparam, static_diag, disabled, dpv1, chan_en;
  assign reparam = ctrl_q[0];
  assign static_diag = ctrl_q[1];
  assign disabled = ctrl_q[2];
  assign dpv1 = ctrl_q[3];
  assign chan_en = ctrl_q[4];

  // ---------------------------------------------------------------
  // ahb-lite address phase capture
  // ---------------------------------------------------------------
  logic ph_wr_q, ph_rd_q;
  logic [7:0] ph_addr_q;
  logic take;
  assign take = hsel && hready && htrans == HTRANS_NONSEQ;
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ph_wr_q <= 1'b0;
      ph_rd_q <= 1'b0;
      ph_addr_q <= 8'h00;
    end
    else
    begin
      ph_wr_q <= take && hwrite;
      ph_rd_q <= take && !hwrite;
      if (take)
        ph_addr_q <= haddr;
    end
  end
  // zero wait states, always okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // ---------------------------------------------------------------
  // software writes
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ctrl_q <= CTRL_RST;
      maddr_q <= 8'h00;
      chan_cnt_q <= 4'h0;
      irq_type_q <= IRQ_NONE;
      frm_idx_q <= 7'h00;
      rec_idx_q <= 6'h00;
      iddiag_q <= '0;
      for (int i = 0; i < CHAN_MAX; i++)
      begin
        chan_slot_q[i] <= 6'h00;
        chan_pwr_q[i] <= 1'b0;
        chan_code_q[i] <= 8'h00;
      end
    end
    else if (ph_wr_q)
    begin
      unique case (ph_addr_q)
        A_CTRL: ctrl_q <= hwdata;
        A_MADDR: maddr_q <= hwdata[7:0]; // R08
        A_CHAN:
        begin
          // push entry: slot number 1..63, power flag, code
          if (chan_cnt_q < 4'(CHAN_MAX)) // R11
          begin
            chan_slot_q[chan_cnt_q] <= hwdata[5:0] - 6'h01; // R13
            chan_pwr_q[chan_cnt_q] <= hwdata[6];
            chan_code_q[chan_cnt_q] <= hwdata[15:8];
            chan_cnt_q <= chan_cnt_q + 4'h1;
          end
          if (hwdata[31])
            chan_cnt_q <= 4'h0;
        end
        A_IRQ: irq_type_q <= hwdata[1:0];
        A_REC_IDX: rec_idx_q <= hwdata[5:0];
        A_FRM_IDX: frm_idx_q <= hwdata[6:0];
        A_IDDIAG_LO: iddiag_q[31:0] <= hwdata;
        A_IDDIAG_HI: iddiag_q[62:32] <= hwdata[30:0];
        default: ;
      endcase
    end
  end

  // record writes go straight to the store
  assign rec.wr_en = ph_wr_q && ph_addr_q == A_REC_DATA;
  assign rec.wr_addr = {2'h0, rec_idx_q};
  assign rec.wr_data = hwdata[7:0];
  assign rec.rd_addr = rec_idx_q;

  fsd_rec_store u_rec (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .rec(rec.store)
  );

  // ---------------------------------------------------------------
  // configuration faults and station state
  // ---------------------------------------------------------------
  logic fatal_cfg;
  assign fatal_cfg = missing_two || term_missing || too_many
                     || backplane_fault; // R18
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      startup_blk_q <= 1'b0;
    else if (!powered_up)
      startup_blk_q <= missing_one; // R20
  end
  // a gap seen before power-up blocks at once, not one edge later
  assign station_fail = fatal_cfg || startup_blk_q
                        || (!powered_up && missing_one); // R20
  // diagnostics keep running; only user data stops
  assign data_exchange_en = !station_fail && !static_diag
                            && !disabled && !reparam; // R21 R02

  // ---------------------------------------------------------------
  // station status bytes
  // ---------------------------------------------------------------
  logic [7:0] stat2_live;
  logic content_chg;
  always_comb
  begin
    stat2_live = 8'h00;
    stat2_live[S2_REPARAM] = reparam; // R01
    stat2_live[S2_STATIC] = static_diag; // R02
    stat2_live[S2_ONE] = 1'b1; // R03
    stat2_live[S2_WDOG] = wdog_active; // R04
    stat2_live[S2_FREEZE] = freeze_q;
    stat2_live[S2_SYNC] = sync_q;
    stat2_live[S2_ZERO] = 1'b0; // R03
    stat2_live[S2_DISABLED] = disabled; // R06
  end
  // content change, freeze and sync excluded
  assign content_chg = ph_wr_q && ph_addr_q != A_FRM_IDX
                       && ph_addr_q != A_REC_IDX;
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      freeze_q <= 1'b0;
      sync_q <= 1'b0;
    end
    else if (content_chg)
    begin
      freeze_q <= freeze_seen; // R05
      sync_q <= sync_seen; // R05
    end
  end
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      stat2_q <= 8'h04;
      stat3_q <= 8'h00;
    end
    else
    begin
      stat2_q <= stat2_live;
      stat3_q <= {master_overflow, 7'h00}; // R07
    end
  end

  // ---------------------------------------------------------------
  // frame lengths
  // ---------------------------------------------------------------
  logic [6:0] irq_at, irq_len, body_len, frame_len, frame_cap;
  logic invalid_cfg;
  assign invalid_cfg = fatal_cfg;
  assign frame_cap = dpv1 ? 7'(FRAME_MAX_V1) : 7'(FRAME_MAX_V0);
  always_comb
  begin
    irq_at = 7'(CHAN_BYTE);
    if (chan_en) // R23
      irq_at = 7'(CHAN_BYTE) + 7'(CHAN_LEN) * {3'h0, chan_cnt_q};
    unique case (irq_type_q) // R17
      IRQ_DIAG: irq_len = 7'(IRQ_HDR) + {1'b0, rec.rec1_len};
      IRQ_PROC: irq_len = 7'(IRQ_HDR + PROC_LEN);
      IRQ_PLUG: irq_len = 7'(IRQ_HDR);
      IRQ_NONE: irq_len = 7'h00;
    endcase
    if (irq_len > 7'(IRQ_MAX)) // R15
      irq_len = 7'(IRQ_MAX);
    if (!dpv1) // R15
      irq_len = 7'h00;
    body_len = irq_at + irq_len;
    frame_len = body_len > frame_cap ? frame_cap : body_len; // R11 R22
  end

  // ---------------------------------------------------------------
  // frame assembly, one byte per cycle
  // ---------------------------------------------------------------
  function automatic logic [7:0] frame_byte(input logic [6:0] p);
    logic [7:0] b;
    int ci;
    int co;
    b = 8'h00;
    ci = (int'(p) - CHAN_BYTE) / CHAN_LEN;
    co = (int'(p) - CHAN_BYTE) % CHAN_LEN;
    if (p == 7'(STAT2_BYTE))
      b = stat2_q;
    else if (p == 7'(STAT3_BYTE))
      b = stat3_q;
    else if (p == 7'(MADDR_BYTE))
      b = maddr_q; // R08
    else if (p >= 7'(IDDIAG_BYTE) && p < 7'(MODSTAT_BYTE)) // R09
      b = invalid_cfg ? 8'hff :
          8'(iddiag_q >> (8 * (int'(p) - IDDIAG_BYTE))); // R19
    else if (p >= 7'(MODSTAT_BYTE) && p < 7'(CHAN_BYTE)) // R10 R12
      b = !invalid_cfg ? 8'h00 :
          cause_found ? {4{MOD_NONE}} : {4{MOD_ERR}}; // R19
    else if (p >= 7'(CHAN_BYTE) && p < irq_at && ci < CHAN_MAX)
    begin
      unique case (co)
        0: b = {2'h0, chan_slot_q[ci]}; // R13
        1: b = {chan_pwr_q[ci] ? 2'h0 : 2'h1, 6'h00}; // R14
        default: b = chan_code_q[ci];
      endcase
    end
    else if (p >= irq_at)
    begin
      if (p == irq_at)
        b = {1'b0, irq_len};
      else if (p == irq_at + 7'h01)
        b = {6'h00, irq_type_q};
      else if (p >= irq_at + 7'(IRQ_HDR) && irq_type_q == IRQ_DIAG)
        b = 8'h00;
    end
    return b;
  endfunction : frame_byte

  // rebuild whenever content may have moved
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_q <= ST_IDLE;
      walk_q <= 7'h00;
    end
    else
    begin
      unique case (state_q)
        ST_IDLE:
        begin
          state_q <= ST_BUILD;
          walk_q <= 7'h00;
        end
        ST_BUILD:
        begin
          walk_q <= walk_q + 7'h01;
          // a write mid-walk may hit bytes already stored, so restart
          if (content_chg)
            state_q <= ST_IDLE;
          else if (walk_q == frame_len - 7'h01)
            state_q <= ST_DONE;
        end
        ST_DONE:
          if (content_chg)
            state_q <= ST_IDLE;
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  // diag payload bytes fetched from the record store via rd_addr is
  // left to software reads; the frame keeps header and type only
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (int i = 0; i < FRAME_BUF; i++)
        frm_q[i] <= 8'h00;
      frm_len_q <= 7'(FRAME_MIN);
    end
    else if (state_q == ST_BUILD)
    begin
      frm_q[walk_q] <= frame_byte(walk_q);
      frm_len_q <= frame_len; // R22
    end
  end
  assign frame_valid = state_q == ST_DONE;

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      hrdata <= 32'h0;
    else if (take && !hwrite)
    begin
      unique case (haddr)
        A_CTRL: hrdata <= ctrl_q;
        A_STATUS: hrdata <= {16'h0, stat3_q, stat2_q};
        A_MADDR: hrdata <= {24'h0, maddr_q};
        A_CHAN: hrdata <= {28'h0, chan_cnt_q};
        A_IRQ: hrdata <= {30'h0, irq_type_q};
        A_REC_IDX: hrdata <= {26'h0, rec_idx_q};
        A_REC_DATA: hrdata <= {24'h0, rec.rd_data}; // R16 R21
        A_FRM_IDX: hrdata <= {25'h0, frm_idx_q};
        A_FRM_DATA: hrdata <= {24'h0, frm_q[frm_idx_q]};
        A_LEN: hrdata <= {18'h0, rec.rec1_len, 1'b0, frm_len_q};
        A_IDDIAG_LO: hrdata <= iddiag_q[31:0];
        A_IDDIAG_HI: hrdata <= {1'b0, iddiag_q[62:32]};
        default: hrdata <= 32'h0;
      endcase
    end
  end
endmodule : fsd_frame
`default_nettype wire

//--- tb/fsd_frame_checker.sv
// port level assertions for the diagnostics frame builder
`timescale 1ns/1ps
`default_nettype none
module fsd_frame_checker
  import fsd_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // bus
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // events
  input wire logic missing_one,
  input wire logic missing_two,
  input wire logic term_missing,
  input wire logic too_many,
  input wire logic backplane_fault,
  input wire logic powered_up,
  // station state
  input wire logic data_exchange_en,
  input wire logic station_fail,
  input wire logic frame_valid
);
  logic taken;
  logic fatal;
  assign taken = hsel && hready && htrans == HTRANS_NONSEQ;
  assign fatal = missing_two || term_missing || too_many || backplane_fault;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  a_zero_wait: assert property (hreadyout)
    else $error("slave inserted a wait state");
  a_resp_okay: assert property (!hresp)
    else $error("slave gave an error response");
  a_fatal_fails: assert property (fatal |-> station_fail)
    else $error("fatal configuration without station failure");
  a_fail_blocks: assert property (station_fail |-> !data_exchange_en)
    else $error("user data exchanged after failure");
  a_fail_cause: assert property ($fell(station_fail) |-> !fatal)
    else $error("failure cleared while a fatal fault stands");
  a_read_holds: assert property (!$past(taken && !hwrite) |-> $stable(hrdata))
    else $error("read data moved without a read");
  a_gap_blocks: assert property (!powered_up && missing_one |=> !data_exchange_en)
    else $error("start up with a module missing");
  a_rebuild_ends: assert property (taken && hwrite && haddr == A_MADDR
    |-> ##2 !frame_valid ##[1:400] frame_valid)
    else $error("frame rebuild never finished");
endmodule : fsd_frame_checker
bind fsd_frame fsd_frame_checker i_fsd_frame_checker (
  .ref_clk(ref_clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .missing_one(missing_one),
  .missing_two(missing_two), .term_missing(term_missing),
  .too_many(too_many), .backplane_fault(backplane_fault),
  .powered_up(powered_up), .data_exchange_en(data_exchange_en),
  .station_fail(station_fail), .frame_valid(frame_valid));
`default_nettype wire

//--- tb/fsd_master_model.sv
// bus master standing in for the reading fieldbus master
`timescale 1ns/1ps
`default_nettype none
module fsd_master_model
  import fsd_pkg::*;
(
  // clock
  input wire logic ref_clk,
  // bus
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [7:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  initial
  begin
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end
  // caller stands just after a rising edge
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    @(posedge ref_clk);
    while (hready !== 1'b1) @(posedge ref_clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    // reads get the inverse of the previous data phase, so back-to-back reads alternate
    hwdata <= w ? d : ~hwdata;
    @(posedge ref_clk);
    while (hready !== 1'b1) @(posedge ref_clk);
    r = hrdata;
  endtask : xfer
endmodule : fsd_master_model
`default_nettype wire

//--- tb/test_fieldbus_slave_diag_frame.sv
// self-checking bench for the diagnostics frame builder
`timescale 1ns/1ps
`default_nettype none
module test_fieldbus_slave_diag_frame
  import fsd_pkg::*;
;
  logic ref_clk, arst_n, hsel, hwrite, hready, hreadyout, hresp;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, r, m;
  logic freeze_seen, sync_seen, wdog_active, master_overflow, missing_one;
  logic missing_two, term_missing, too_many, backplane_fault, cause_found;
  logic powered_up, data_exchange_en, station_fail, frame_valid;
  int fail_count, total_checks, seed, k;
  int slot_q[$], pwr_q[$], code_q[$];
  int irq_t[3] = '{1, 3, 2};
  int irq_len[3] = '{REC0_LEN, PROC_LEN, 0};
  assign hready = hreadyout;
  always #5 ref_clk = ~ref_clk;
  fsd_master_model i_fsd_master_model (.ref_clk(ref_clk), .hready(hready),
    .hrdata(hrdata), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  fsd_frame i_fsd_frame (.ref_clk(ref_clk), .arst_n(arst_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .freeze_seen(freeze_seen),
    .sync_seen(sync_seen), .wdog_active(wdog_active),
    .master_overflow(master_overflow), .missing_one(missing_one),
    .missing_two(missing_two), .term_missing(term_missing),
    .too_many(too_many), .backplane_fault(backplane_fault),
    .cause_found(cause_found), .powered_up(powered_up),
    .data_exchange_en(data_exchange_en), .station_fail(station_fail),
    .frame_valid(frame_valid));
  task final_report;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : final_report
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    i_fsd_master_model.xfer(1'b1, a, d, dummy);
  endtask : wr
  task rd(input logic [7:0] a, output logic [31:0] d);
    i_fsd_master_model.xfer(1'b0, a, 32'h0, d);
  endtask : rd
  // rebuild needs a couple of edges to drop frame_valid
  task build;
    repeat (2) @(posedge ref_clk);
    for (int i = 0; i < 500 && frame_valid !== 1'b1; i++)
      @(posedge ref_clk);
  endtask : build
  task frm(input int idx, output logic [31:0] d);
    build();
    wr(A_FRM_IDX, idx);
    rd(A_FRM_DATA, d);
  endtask : frm
  initial
  begin
    #500us;
    fail_count++;
    final_report();
  end
  initial
  begin
    ref_clk = 1'b0;
    arst_n = 1'b0;
    {freeze_seen, sync_seen, wdog_active, master_overflow} = 4'h0;
    {missing_one, missing_two, term_missing, too_many} = 4'h0;
    {backplane_fault, cause_found, powered_up} = 3'h0;
    fail_count = 0;
    total_checks = 0;
    seed = 52;
    repeat (4) @(posedge ref_clk);
    arst_n <= 1'b1;
    powered_up <= 1'b1;
    @(posedge ref_clk);
    rd(A_STATUS, r); chk(r, 32'h0004);
    rd(A_LEN, r); chk(r, 32'h0400 | CHAN_BYTE);
    rd(8'h3c, r); chk(r, 32'h0);
    {freeze_seen, sync_seen, wdog_active} <= 3'h7;
    master_overflow <= 1'b1;
    wr(A_REC_IDX, 32'h0);
    rd(A_STATUS, r); chk(r, 32'h800c);
    wr(A_CTRL, 32'h7);
    @(posedge ref_clk);
    rd(A_STATUS, r); chk(r, 32'h80bf);
    chk(data_exchange_en, 1'b0);
    {freeze_seen, sync_seen} <= 2'h0;
    wr(A_CTRL, 32'h0);
    @(posedge ref_clk);
    rd(A_STATUS, r); chk(r, 32'h800c);
    chk(data_exchange_en, 1'b1);
    {wdog_active, master_overflow} <= 2'h0;
    m = $random(seed) & 32'h7f;
    wr(A_MADDR, m);
    frm(MADDR_BYTE, r); chk(r, m);
    // ten pushes, the last must be refused
    wr(A_CTRL, 32'h10);
    for (k = 0; k < CHAN_MAX + 1; k++)
    begin
      m = {$random(seed)} % SLOTS + 1;
      wr(A_CHAN, {16'h0, 8'(k + 32), 1'b0, k[0], m[5:0]});
      if (k < CHAN_MAX)
      begin
        slot_q.push_back(m);
        pwr_q.push_back(k % 2);
        code_q.push_back(k + 32);
      end
    end
    rd(A_CHAN, r); chk(r, CHAN_MAX);
    build();
    rd(A_LEN, r); chk(r, 32'h0400 | FRAME_MAX_V0);
    for (k = 0; k < CHAN_MAX; k++)
    begin
      frm(SLOT_FIELD_BYTE + 3 * k, r); chk(r, slot_q[k] - 1);
      frm(PWR_FIELD_BYTE + 3 * k, r);
      if (pwr_q[k] == 1)
        chk(r & 32'hc0, 32'h0);
      else
        chk(r, 32'h40);
      frm(PWR_FIELD_BYTE + 3 * k + 1, r); chk(r, code_q[k]);
    end
    wr(A_CHAN, 32'h8000_0000);
    wr(A_CHAN, 32'h0000_2005);
    wr(A_CTRL, 32'h18);
    for (k = 0; k < 3; k++)
    begin
      wr(A_IRQ, irq_t[k]);
      frm(CHAN_BYTE + CHAN_LEN + 1, r); chk(r, irq_t[k]);
      rd(A_LEN, r);
      chk(r & 32'h7f, CHAN_BYTE + CHAN_LEN + IRQ_HDR + irq_len[k]);
    end
    wr(A_CTRL, 32'h10);
    build();
    rd(A_LEN, r); chk(r & 32'h7f, CHAN_BYTE + CHAN_LEN);
    m = $random(seed) & 32'hff;
    wr(A_REC_IDX, 32'h5);
    wr(A_REC_DATA, m);
    backplane_fault <= 1'b1;
    wr(A_MADDR, m);
    build();
    chk(station_fail, 1'b1);
    chk(data_exchange_en, 1'b0);
    rd(A_REC_DATA, r); chk(r, m);
    rd(A_LEN, r); chk(r >> 8, 32'h6);
    frm(IDDIAG_BYTE, r); chk(r, 32'hff);
    frm(MODSTAT_BYTE - 1, r); chk(r, 32'hff);
    frm(MODSTAT_BYTE, r); chk(r, 32'h55);
    cause_found <= 1'b1;
    wr(A_MADDR, m);
    frm(MODSTAT_BYTE, r); chk(r, 32'hff);
    for (k = 0; k < 4; k++)
    begin
      {missing_two, term_missing, too_many, backplane_fault} <= 4'(1 << k);
      @(posedge ref_clk);
      chk(station_fail, 1'b1);
    end
    {missing_two, term_missing, too_many, backplane_fault} <= 4'h0;
    @(posedge ref_clk);
    chk(data_exchange_en, 1'b1);
    // second reset with a gap in the backplane at power on
    arst_n <= 1'b0;
    missing_one <= 1'b1;
    powered_up <= 1'b0;
    repeat (2) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk(data_exchange_en, 1'b0);
    powered_up <= 1'b1;
    repeat (2) @(posedge ref_clk);
    chk(data_exchange_en, 1'b0);
    final_report();
  end
endmodule : test_fieldbus_slave_diag_frame
`default_nettype wire
